/* hdl/rc_tick_divider.sv */
/*
  Stand-in for the private internal RC oscillator: a free-running divider
  that produces a one-cycle tick, independent of the oscillator selection.
  Assumes the system clock always runs.
*/
`timescale 1ns/100ps
module rc_tick_divider
  import reset_delay_pkg::*;
#(
  parameter int TICK_CYCLES = RC_TICK_CYCLES
) (
  input  wire logic   clock_in,
  input  wire logic   resetn_in,
  rc_tick_if.source   tick_port
);

  logic [15:0] count;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count          <= 16'h0000;
      tick_port.tick <= 1'b0;
    end else if (count == 16'(TICK_CYCLES - 1)) begin
      count          <= 16'h0000;
      tick_port.tick <= 1'b1;
    end else begin
      count          <= count + 16'h0001;
      tick_port.tick <= 1'b0;
    end
  end

endmodule

/* hdl/rc_tick_if.sv */
/*
  Carries the private RC oscillator tick from its divider to the sequencer.
  Assumes both ends share the system clock.
*/
`timescale 1ns/100ps
interface rc_tick_if;
  logic tick;
  modport source (output tick);
  modport sink   (input  tick);
endinterface

/* hdl/reset_delay_pkg.sv */
/*
  Constants shared by the reset delay sequencer: register map, configuration
  word layout, oscillator modes and timing counts.
  Assumes a single 250 MHz system clock.
*/
package reset_delay_pkg;

  localparam int          CLOCK_PERIOD_PS     = 4000;
  localparam int          DELAY_TIME_MS       = 18;
  // Private RC oscillator model: one tick every 1 us of system clock.
  localparam int          RC_TICK_TIME_NS     = 1000;
  localparam int          RC_TICK_CYCLES      = (RC_TICK_TIME_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int          DELAY_TICKS         = DELAY_TIME_MS * 1000000 / RC_TICK_TIME_NS;

  localparam logic [11:0] CONFIG_WORD_RESET   = 12'hFFF;
  localparam int          CODE_PROTECT_MSB    = 11;
  localparam int          CODE_PROTECT_LSB    = 3;
  localparam int          WATCHDOG_ENABLE_BIT = 2;
  localparam int          OSC_SELECT_MSB      = 1;
  localparam int          OSC_SELECT_LSB      = 0;

  localparam logic [11:0] ADDR_CONFIG_WORD    = 12'h000;
  localparam logic [11:0] ADDR_STATUS         = 12'h004;
  localparam logic [11:0] ADDR_CONTROL        = 12'h008;

  localparam logic [1:0]  RESP_OKAY           = 2'h0;
  localparam logic [1:0]  RESP_SLVERR         = 2'h2;

  typedef enum logic [1:0] {
    low_power_crystal_mode  = 2'h0,
    standard_crystal_mode   = 2'h1,
    high_speed_crystal_mode = 2'h2,
    resistor_capacitor_mode = 2'h3
  } osc_mode_t;

endpackage

/* hdl/reset_delay_sequencer.sv */
/*
  Reset delay timer and configuration word decode with an AXI4-Lite slave.
  Assumes pins synchronous to clock_in and an external supervisor that
  drives the master clear pin low on brown-out.
*/
// Functional notes
// - Every reset runs a nominal 18 ms delay, independent of oscillator mode.
// - The delay counts ticks of a private oscillator, not the system oscillator.
// - The core stays held in reset while the delay timer counts.
// - The count starts only after the master clear pin is high.
// - A watchdog time-out restarts the delay, also when waking from halt.
// - Bits 11 to 3 are code protect bits; 0 means protected.
// - Bit 2 set enables the watchdog timer.
// - Bits 1 to 0 select low-power, standard or high-speed crystal, or resistor-capacitor.
// - Older variants have a single code protect bit.
// - Factory-programmed variants fix the oscillator field at manufacture.
`timescale 1ns/100ps
module reset_delay_sequencer
  import reset_delay_pkg::*;
#(
  parameter int          DELAY_COUNT      = DELAY_TICKS,
  parameter bit          LEGACY_VARIANT   = 1'b0,
  parameter bit          FACTORY_OSC      = 1'b0,
  parameter logic [1:0]  FACTORY_OSC_MODE = 2'h3
) (
  // Clock and reset.
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  // Device pins and events.
  input  wire logic        master_clear_pin_in,
  input  wire logic        watchdog_timeout_in,
  input  wire logic [11:0] config_word_in,
  // Decoded configuration and core reset.
  output logic             core_reset_out,
  output logic             watchdog_enable_bit_out,
  output logic [1:0]       oscillator_select_field_out,
  output logic             code_protect_out,
  // AXI4-Lite write address.
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  // AXI4-Lite write data.
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response.
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address.
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  // AXI4-Lite read data.
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  typedef enum logic [1:0] {
    st_wait_pin,
    st_counting,
    st_running
  } seq_state_t;

  rc_tick_if tick_bus ();

  seq_state_t  state;
  logic [31:0] delay_count;
  logic [11:0] config_word;
  logic        config_loaded;
  logic        soft_reset_req;
  logic        restart_seen;
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        delay_done;
  logic        restart;
  logic [1:0]  next_osc;
  logic [8:0]  protect_field;

  rc_tick_divider #(
    .TICK_CYCLES (RC_TICK_CYCLES)
  ) u_rc_tick (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .tick_port (tick_bus.source)
  );

  ////////////////////////////////////////////////////////////////////////////

  // The configuration word is captured once, after reset is released.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      config_word   <= CONFIG_WORD_RESET;
      config_loaded <= 1'b0;
    end else if (!config_loaded) begin
      config_word   <= config_word_in;
      config_loaded <= 1'b1;
    end
  end

  assign protect_field = config_word[CODE_PROTECT_MSB:CODE_PROTECT_LSB];

  always_comb begin
    if (FACTORY_OSC) begin
      next_osc = FACTORY_OSC_MODE;
    end else begin
      next_osc = config_word[OSC_SELECT_MSB:OSC_SELECT_LSB];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      watchdog_enable_bit_out     <= 1'b0;
      oscillator_select_field_out <= 2'h3;
      code_protect_out            <= 1'b0;
    end else begin
      watchdog_enable_bit_out     <= config_word[WATCHDOG_ENABLE_BIT];
      oscillator_select_field_out <= next_osc;
      if (LEGACY_VARIANT) begin
        code_protect_out <= ~protect_field[0];
      end else begin
        code_protect_out <= ~(&protect_field);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign delay_done = (delay_count >= 32'(DELAY_COUNT - 1));
  assign restart    = watchdog_timeout_in | soft_reset_req;

  // Sequencer; the count step never looks at the oscillator mode.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state       <= st_wait_pin;
      delay_count <= 32'h00000000;
    end else if (!master_clear_pin_in || !config_loaded) begin
      state       <= st_wait_pin;
      delay_count <= 32'h00000000;
    end else begin
      unique case (state)
        st_wait_pin: begin
          state       <= st_counting;
          delay_count <= 32'h00000000;
        end
        st_counting: begin
          if (restart) begin
            delay_count <= 32'h00000000;
          end else if (tick_bus.tick) begin
            if (delay_done) begin
              state <= st_running;
            end else begin
              delay_count <= delay_count + 32'h00000001;
            end
          end
        end
        st_running: begin
          if (restart) begin
            state       <= st_counting;
            delay_count <= 32'h00000000;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_reset_out <= 1'b1;
    end else begin
      core_reset_out <= (state != st_running) || restart || !master_clear_pin_in;
    end
  end

  // Sticky flag: a watchdog restart was seen since software last cleared it.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      restart_seen <= 1'b0;
    end else if (watchdog_timeout_in) begin
      restart_seen <= 1'b1;
    end else if (aw_held && w_held && !s_axi_bvalid && aw_addr == ADDR_STATUS && w_strb[0] && w_data[2]) begin
      restart_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr)
          ADDR_CONTROL, ADDR_STATUS: s_axi_bresp <= RESP_OKAY;
          ADDR_CONFIG_WORD:          s_axi_bresp <= RESP_SLVERR;
          default:                   s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control bit 0 requests a software restart of the delay; self-clearing.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      soft_reset_req <= 1'b0;
    end else begin
      soft_reset_req <= aw_held && w_held && !s_axi_bvalid && aw_addr == ADDR_CONTROL && w_strb[0] && w_data[0];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CONFIG_WORD: s_axi_rdata <= {20'h00000, config_word};
        ADDR_STATUS:      s_axi_rdata <= {29'h0000000, restart_seen, state == st_counting, core_reset_out};
        ADDR_CONTROL:     s_axi_rdata <= 32'h00000000;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* testbench/reset_delay_sequencer_assertions.sv */
/*
  Checker on the reset delay sequencer ports.
  Assumes config_word_in only changes while reset is asserted.
*/
`timescale 1ns/100ps
module reset_delay_sequencer_assertions
  import reset_delay_pkg::*;
#(
  parameter int         DELAY_COUNT      = DELAY_TICKS,
  parameter bit         LEGACY_VARIANT   = 1'b0,
  parameter bit         FACTORY_OSC      = 1'b0,
  parameter logic [1:0] FACTORY_OSC_MODE = 2'h3
) (
  // Clock, reset and pins.
  input wire logic        clock_in,
  input wire logic        resetn_in,
  input wire logic        master_clear_pin_in,
  input wire logic        watchdog_timeout_in,
  input wire logic [11:0] config_word_in,
  // Decoded outputs.
  input wire logic        core_reset_out,
  input wire logic        watchdog_enable_bit_out,
  input wire logic [1:0]  oscillator_select_field_out,
  input wire logic        code_protect_out,
  // Register bus.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  localparam int FLOOR = (DELAY_COUNT - 1) * RC_TICK_CYCLES;
  int         high_cycles;
  logic [1:0] age;
  logic [1:0] osc_expect;
  logic       protect_expect;
  // Expected decode follows the variant the bound instance was built as.
  assign osc_expect     = FACTORY_OSC ? FACTORY_OSC_MODE : config_word_in[1:0];
  assign protect_expect = LEGACY_VARIANT ? !config_word_in[3] : !(&config_word_in[11:3]);
  // The tick phase is free, so the floor allows one tick of slack.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      high_cycles <= 0;
      age         <= 2'h0;
    end else begin
      high_cycles <= master_clear_pin_in ? high_cycles + 1 : 0;
      age         <= (age == 2'h3) ? age : age + 2'h1;
    end
  end
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_config_write;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == ADDR_CONFIG_WORD;
  endsequence
  a_pin_low_hold: assert property (!master_clear_pin_in |=> core_reset_out)
    else $error("core not held after pin low");
  a_watchdog_restart: assert property (watchdog_timeout_in |=> core_reset_out)
    else $error("core not held after watchdog");
  a_delay_floor: assert property ($fell(core_reset_out) |-> high_cycles >= FLOOR)
    else $error("core released early");
  a_osc_decode: assert property (age == 2'h3 |-> oscillator_select_field_out == osc_expect)
    else $error("oscillator field wrong");
  a_watchdog_bit: assert property (age == 2'h3 |-> watchdog_enable_bit_out == config_word_in[2])
    else $error("watchdog enable wrong");
  a_code_protect: assert property (age == 2'h3 |-> code_protect_out == protect_expect)
    else $error("code protect wrong");
  a_config_readonly: assert property (s_config_write |-> ##2 s_axi_bresp == RESP_SLVERR)
    else $error("config write accepted");
  a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule

bind reset_delay_sequencer reset_delay_sequencer_assertions #(
  .DELAY_COUNT      (DELAY_COUNT),
  .LEGACY_VARIANT   (LEGACY_VARIANT),
  .FACTORY_OSC      (FACTORY_OSC),
  .FACTORY_OSC_MODE (FACTORY_OSC_MODE)
) checker_inst (.*);

/* testbench/supervisor_model.sv */
/*
  External supervisor: holds master clear low while the supply is low
  and for a few cycles after it recovers.
  Assumes the bench gives the supply state synchronous to clock_in.
*/
`timescale 1ns/100ps
module supervisor_model #(
  parameter int HOLD_CYCLES = 8
) (
  // Clock and supply state.
  input  wire logic clock_in,
  input  wire logic supply_ok_in,
  // Master clear pin, high when released.
  output logic      master_clear_pin_out
);
  int hold = HOLD_CYCLES;
  always @(posedge clock_in) begin
    if (!supply_ok_in) hold <= HOLD_CYCLES;
    else if (hold != 0) hold <= hold - 1;
  end
  assign master_clear_pin_out = (hold == 0);
endmodule

/* testbench/testbench.sv */
/*
  Self-checking bench for the reset delay sequencer.
  Assumes the supervisor model is the only driver of master clear.
*/
`timescale 1ns/100ps
module testbench;
  import reset_delay_pkg::*;
  localparam int D  = 4;
  localparam int LO = (D - 1) * RC_TICK_CYCLES;
  localparam int HI = D * RC_TICK_CYCLES + 28;
  logic clock_in, resetn_in, supply_ok, watchdog_timeout_in, s_axi_awvalid, s_axi_wvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] config_word_in, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [1:0]  rs;
  wire logic master_clear_pin_in, core_reset_out, watchdog_enable_bit_out, code_protect_out;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  oscillator_select_field_out, s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic legacy_core_reset, legacy_protect;
  wire logic [1:0]  legacy_osc;
  int fail_count, n_tests, cyc, n;
  supervisor_model supervisor_model_inst (.clock_in, .supply_ok_in(supply_ok),
    .master_clear_pin_out(master_clear_pin_in));
  reset_delay_sequencer #(.DELAY_COUNT(D)) reset_delay_sequencer_inst (.*, .s_axi_wstrb(4'hF));
  // Older, factory-programmed variant on the same pins; its bus stays idle.
  reset_delay_sequencer #(.DELAY_COUNT(D), .LEGACY_VARIANT(1'b1), .FACTORY_OSC(1'b1), .FACTORY_OSC_MODE(2'h1))
    reset_delay_sequencer_legacy_inst (
    .clock_in, .resetn_in, .master_clear_pin_in, .watchdog_timeout_in, .config_word_in,
    .core_reset_out(legacy_core_reset), .watchdog_enable_bit_out(), .oscillator_select_field_out(legacy_osc),
    .code_protect_out(legacy_protect), .s_axi_awvalid(1'b0), .s_axi_awready(), .s_axi_awaddr(12'h000),
    .s_axi_wvalid(1'b0), .s_axi_wready(), .s_axi_wdata(32'h00000000), .s_axi_wstrb(4'h0), .s_axi_bvalid(),
    .s_axi_bready(1'b0), .s_axi_bresp(), .s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_araddr(12'h000),
    .s_axi_rvalid(), .s_axi_rready(1'b0), .s_axi_rdata(), .s_axi_rresp());
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic ta = 1'b0;
    logic tw = 1'b0;
    @(posedge clock_in);
    s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1; s_axi_wdata <= d; s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clock_in);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(posedge clock_in); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clock_in);
    s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
    do @(posedge clock_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock_in); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 1'b0;
  endtask
  // Cycles until the core is let go, bounded.
  task automatic settle;
    n = 0;
    while (core_reset_out !== 1'b0 && n < 2 * HI) begin
      @(posedge clock_in);
      n++;
    end
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      close_out;
    end
  end
  initial begin
    {resetn_in, watchdog_timeout_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {config_word_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    supply_ok = 1'b1;
    for (int i = 0; i < 6; i++) begin
      resetn_in <= 1'b0;
      config_word_in <= (i < 4) ? {10'h3FE, i[1:0]} : (i == 4) ? 12'h7FB : 12'hFF7;
      repeat (16) @(posedge clock_in);
      chk("core_reset", 1, core_reset_out);
      resetn_in <= 1'b1;
      settle;
      chk("delay_window", 1, n >= LO && n <= HI);
      chk("osc_select", (i < 4) ? i : 3, oscillator_select_field_out);
      chk("watchdog_enable", i == 5, watchdog_enable_bit_out);
      chk("code_protect", i >= 4, code_protect_out);
      chk("legacy_release", 0, legacy_core_reset);
      chk("legacy_protect", i == 5, legacy_protect);
      chk("factory_osc", 1, legacy_osc);
    end
    rd_reg(ADDR_CONFIG_WORD);
    chk("config_read", 32'h00000FF7, rd);
    wr_reg(ADDR_CONFIG_WORD, 32'h00000000);
    chk("config_write_resp", RESP_SLVERR, rs);
    rd_reg(12'h00C);
    chk("unmapped_resp", RESP_SLVERR, rs);
    chk("unmapped_data", 32'h00000000, rd);
    wr_reg(ADDR_CONTROL, 32'h00000001);
    chk("control_resp", RESP_OKAY, rs);
    @(posedge clock_in);
    chk("soft_restart", 1, core_reset_out);
    settle;
    chk("soft_delay", 1, n >= LO - 4 && n <= HI);
    supply_ok <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk("brownout_reset", 1, core_reset_out);
    supply_ok <= 1'b1;
    repeat (HI / 2) @(posedge clock_in);
    rd_reg(ADDR_STATUS);
    chk("status_counting", 3, rd[1:0]);
    supply_ok <= 1'b0;
    @(posedge clock_in) supply_ok <= 1'b1;
    settle;
    chk("delay_restart", 1, n >= LO && n <= HI + 12);
    @(posedge clock_in) watchdog_timeout_in <= 1'b1;
    @(posedge clock_in) watchdog_timeout_in <= 1'b0;
    @(posedge clock_in);
    chk("watchdog_reset", 1, core_reset_out);
    settle;
    chk("watchdog_delay", 1, n >= LO - 2 && n <= HI);
    rd_reg(ADDR_STATUS);
    chk("status_sticky", 4, rd[2:0]);
    wr_reg(ADDR_STATUS, 32'h00000004);
    chk("status_write_resp", RESP_OKAY, rs);
    rd_reg(ADDR_STATUS);
    chk("status_clear", 0, rd[2:0]);
    close_out;
  end
endmodule
